// File: dv/abx_tb.sv
// self-checking bench for the bias, excitation and status register bank
`timescale 1ns/1ns
module testbench
   import abx_pkg::*;
;
   // ***********************************
   // signals
   // ***********************************
   typedef struct packed {
      logic [11:0] addr;
      logic [15:0] data;
   } abx_row_s;
   localparam logic [11:0] MAG_UA [10] = '{12'h000, 12'h00A, 12'h032,
      12'h064, 12'h0FA, 12'h1F4, 12'h2EE, 12'h3E8, 12'h5DC, 12'h7D0};
   localparam abx_row_s ROWS [19] = '{
      '{ABX_ADDR_EXC, 16'h0F30}, '{ABX_ADDR_EXC, 16'h1E40},
      '{ABX_ADDR_EXC, 16'h2D50}, '{ABX_ADDR_EXC, 16'h3C60},
      '{ABX_ADDR_EXC, 16'h4B70}, '{ABX_ADDR_EXC, 16'h5A80},
      '{ABX_ADDR_EXC, 16'h6990}, '{ABX_ADDR_EXC, 16'h78A0},
      '{ABX_ADDR_EXC, 16'h87B0}, '{ABX_ADDR_EXC, 16'h90C0},
      '{ABX_ADDR_EXC, 16'h1100}, '{ABX_ADDR_EXC, 16'h22D0},
      '{ABX_ADDR_EXC, 16'h33E0}, '{ABX_ADDR_EXC, 16'h44FF},
      '{ABX_ADDR_CTRL1, 16'h0041}, '{ABX_ADDR_CTRL1, 16'h082A},
      '{ABX_ADDR_CTRL1, 16'h1015}, '{ABX_ADDR_CTRL1, 16'h1860},
      '{ABX_ADDR_CTRL1, 16'h0000}};
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   abx_mon_s    mon = '{default: 1'b0, uvlo: 1'b1};
   abx_analog_s analog;
   logic        irq;
   logic [31:0] rd;
   logic        err;
   logic [15:0] ctrl_v = 16'h0000;
   logic [15:0] exc_v = 16'h0FF0;
   logic [15:0] m;
   int          miscompares = 0;
   int          n_checks = 0;
   int          cycles = 0;

   always #10 clk = ~clk;

   abx_regs i_dut (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .i_pstrb(4'h3), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_mon(mon),
      .o_analog(analog), .o_irq(irq));

   // ***********************************
   // tasks
   // ***********************************
   task automatic chk(input string name, input logic [63:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, seen);
         miscompares++;
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      chk("pready", pready, 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic logic [15:0] onehot(input logic [3:0] c);
      return (c <= 4'hC) ? (16'h0001 << c) : 16'h0000;
   endfunction : onehot

   function automatic abx_analog_s exp_an(input logic [15:0] c, e);
      return '{c[6], c[5:0], MAG_UA[e[15:12]], onehot(e[7:4]),
               onehot(e[11:8]), c[12:11] != 2'h0, c[12:11] == 2'h2};
   endfunction : exp_an

   task automatic report_and_stop();
      if (miscompares == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         miscompares++;
         report_and_stop();
      end
   end

   // ***********************************
   // main sequence
   // ***********************************
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      mon.ref_l0 <= 1'b1;
      mon.ref_l1 <= 1'b1;
      foreach (ROWS[i]) begin
         apb(1'b1, ROWS[i].addr, {16'h0, ROWS[i].data});
         chk("wr_err", err, 1'b0);
         if (ROWS[i].addr == ABX_ADDR_EXC) begin
            exc_v = ROWS[i].data & 16'hFFF0;
            m = 16'hFFF0;
         end else begin
            ctrl_v = ROWS[i].data;
            m = 16'h187F;
         end
         repeat (2) @(negedge clk);
         chk("analog", analog, exp_an(ctrl_v, exc_v));
         apb(1'b0, ROWS[i].addr, 32'h0);
         chk("readback", rd & {16'hFFFF, m}, ROWS[i].data & m);
         apb(1'b0, ABX_ADDR_STAT, 32'h0);
         chk("ref_flags", rd[1:0], {ctrl_v[12:11] == 2'h2,
             ctrl_v[12:11] != 2'h0});
      end
      mon <= '{overrange: 4'hA, uvlo: 1'b1, rail: 4'h5, default: 1'b0};
      apb(1'b1, 12'h0D4, 32'h0000FFFF);
      chk("unmapped_err", err, 1'b1);
      apb(1'b0, 12'h0D4, 32'h0);
      chk("unmapped_rd", {err, rd}, {1'b1, 32'h0});
      apb(1'b0, ABX_ADDR_STAT, 32'h0);
      chk("status", rd, 32'h00000AD4);
      apb(1'b1, ABX_ADDR_STAT, 32'h000000C0);
      apb(1'b0, ABX_ADDR_STAT, 32'h0);
      chk("por_clr", rd[7:6], 2'h1);
      // interrupt: masked event, unmask, clear
      mon.overrange <= 4'h0;
      apb(1'b1, ABX_ADDR_IRQ_MSK, 32'h0);
      apb(1'b1, ABX_ADDR_IRQ_ST, 32'h0000FFFF);
      mon.overrange <= 4'h1;
      repeat (3) @(posedge clk);
      apb(1'b0, ABX_ADDR_IRQ_ST, 32'h0);
      chk("irq_st", {rd[8], irq}, 2'h2);
      apb(1'b1, ABX_ADDR_IRQ_MSK, 32'h00000100);
      @(negedge clk);
      chk("irq_on", irq, 1'b1);
      apb(1'b1, ABX_ADDR_IRQ_ST, 32'h00000100);
      @(negedge clk);
      chk("irq_off", irq, 1'b0);
      // reset in mid-run restores defaults
      @(posedge clk);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("rst_analog", analog, '0);
      apb(1'b0, ABX_ADDR_EXC, 32'h0);
      chk("rst_exc", rd, 32'h00000FF0);
      apb(1'b0, ABX_ADDR_STAT, 32'h0);
      chk("rst_por", rd[7], 1'b1);
      chk("rst_uv", rd[6], 1'b1);
      report_and_stop();
   end
endmodule : testbench

// File: src/abx_pkg.sv
// package for the bias, excitation and status register bank
package abx_pkg;
   // ***********************************
   // register map (word indices and byte addresses)
   // ***********************************
   localparam logic [11:0] ABX_IDX_CTRL1   = 12'h030;
   localparam logic [11:0] ABX_IDX_EXC     = 12'h031;
   localparam logic [11:0] ABX_IDX_STAT    = 12'h032;
   localparam logic [11:0] ABX_IDX_IRQ_ST  = 12'h033;
   localparam logic [11:0] ABX_IDX_IRQ_MSK = 12'h034;
   localparam logic [11:0] ABX_ADDR_CTRL1   = {ABX_IDX_CTRL1[9:0], 2'h0};
   localparam logic [11:0] ABX_ADDR_EXC     = {ABX_IDX_EXC[9:0], 2'h0};
   localparam logic [11:0] ABX_ADDR_STAT    = {ABX_IDX_STAT[9:0], 2'h0};
   localparam logic [11:0] ABX_ADDR_IRQ_ST  = {ABX_IDX_IRQ_ST[9:0], 2'h0};
   localparam logic [11:0] ABX_ADDR_IRQ_MSK = {ABX_IDX_IRQ_MSK[9:0], 2'h0};

   // ***********************************
   // field positions and resets
   // ***********************************
   localparam int ABX_MON_LO  = 11;
   localparam int ABX_VBC_BIT = 6;
   localparam int ABX_MAG_LO  = 12;
   localparam int ABX_MUXB_LO = 8;
   localparam int ABX_MUXA_LO = 4;
   localparam int ABX_POR_BIT = 7;
   localparam int ABX_UV_BIT  = 6;
   localparam logic [3:0] ABX_MUX_RST  = 4'hF;
   localparam logic [3:0] ABX_MUX_LAST = 4'hC;
   localparam logic [3:0] ABX_MAG_LAST = 4'h9;
   localparam logic [1:0] ABX_MON_OFF  = 2'h0;
   localparam logic [1:0] ABX_MON_L0   = 2'h1;
   localparam logic [1:0] ABX_MON_BOTH = 2'h2;
   localparam logic [1:0] ABX_MON_L0PT = 2'h3;

   // decoded analog controls
   typedef struct packed {
      logic        common_en;
      logic [5:0]  input_en;
      logic [11:0] magnitude_ua;
      logic [15:0] source_a_onehot;
      logic [15:0] source_b_onehot;
      logic        ref_l0_en;
      logic        ref_l1_en;
   } abx_analog_s;

   // raw monitor inputs
   typedef struct packed {
      logic [3:0] overrange;
      logic       uvlo;
      logic [3:0] rail;
      logic       ref_l1;
      logic       ref_l0;
   } abx_mon_s;
endpackage : abx_pkg

// File: src/abx_regs.sv
// register bank for bias, excitation current and fault status
// ***********************************
// Summary of operation
// - common input bias enable routes bias to common input pin.
// - six bias enables connect bias to inputs 0..5; reset off.
// - magnitude field 15:12 of 0x31 drives both sources alike.
// - magnitude codes 0..9 map off, 10..2000 uA.
// - source A pin select 7:4, codes 0..12 pins, others off, reset F.
// - source B pin select 11:8 same as A, reset F.
// - status 11:8 report integrator stage over-range, reset 0.
// - power-on flag set at reset, held until software writes 1 to status 7.
// - status 6 read-only undervoltage flag, reset reads 1.
// - status 5,4 positive output near upper or lower rail.
// - status 3,2 negative output near upper or lower rail.
// - status 1 reference below a third of supply span.
// - status 0 reference below 0.3 V, missing reference.
// - monitor select field enables the reference comparators.
// ***********************************
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns
module abx_regs
   import abx_pkg::*;
(
   // clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   // apb slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   input  wire logic [3:0]  i_pstrb,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // analog monitors
   input  wire abx_mon_s    i_mon,
   // analog controls
   output abx_analog_s      o_analog,
   output logic             o_irq
);
   typedef enum logic [2:0] {
      ABX_IDLE   = 3'b001,
      ABX_ACCESS = 3'b010,
      ABX_DONE   = 3'b100
   } abx_state_e;

   abx_state_e  state;
   abx_state_e  next_state;
   logic [15:0] ctrl1;
   logic [15:0] exc;
   logic        por_flag;
   logic [15:0] irq_st;
   logic [15:0] irq_msk;
   abx_mon_s    mon_s1;
   abx_mon_s    mon_s2;
   logic [15:0] stat_prev;
   // undervoltage flag idles high, so its synchroniser resets high
   localparam abx_mon_s ABX_MON_RST = '{default: 1'b0, uvlo: 1'b1};

   // ***********************************
   // bus decode
   // ***********************************
   wire setup    = i_psel && !i_penable;
   wire acc      = i_psel && i_penable && (state == ABX_ACCESS);
   wire wr       = acc && i_pwrite;
   wire lo_ok    = i_pstrb[0];
   wire hi_ok    = i_pstrb[1];
   wire hit_c1   = (i_paddr == ABX_ADDR_CTRL1);
   wire hit_exc  = (i_paddr == ABX_ADDR_EXC);
   wire hit_stat = (i_paddr == ABX_ADDR_STAT);
   wire hit_ist  = (i_paddr == ABX_ADDR_IRQ_ST);
   wire hit_msk  = (i_paddr == ABX_ADDR_IRQ_MSK);
   wire mapped   = hit_c1 | hit_exc | hit_stat | hit_ist | hit_msk;
   wire wr_c1    = wr && hit_c1;
   wire wr_exc   = wr && hit_exc;
   wire wr_stat  = wr && hit_stat;
   wire wr_ist   = wr && hit_ist;
   wire wr_msk   = wr && hit_msk;

   always_comb begin
      next_state = state;
      unique case (state)
         ABX_IDLE:   if (setup) next_state = ABX_ACCESS;
         ABX_ACCESS: next_state = ABX_IDLE;
         ABX_DONE:   next_state = ABX_IDLE;
         default:    next_state = ABX_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) state <= ABX_IDLE;
      else state <= next_state;
   end

   // one wait-free access cycle after setup
   assign o_pready  = (state == ABX_ACCESS);
   assign o_pslverr = acc && !mapped;

   // ***********************************
   // monitor synchroniser
   // ***********************************
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         mon_s1 <= ABX_MON_RST;
         mon_s2 <= ABX_MON_RST;
      end else begin
         mon_s1 <= i_mon;
         mon_s2 <= mon_s1;
      end
   end

   // ***********************************
   // control registers
   // ***********************************
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl1   <= 16'h0000;
         exc     <= {4'h0, ABX_MUX_RST, ABX_MUX_RST, 4'h0};
         irq_msk <= 16'h0000;
      end else begin
         if (wr_c1 && lo_ok) ctrl1[7:0] <= i_pwdata[7:0];
         if (wr_c1 && hi_ok) ctrl1[15:8] <= i_pwdata[15:8];
         if (wr_exc && lo_ok) exc[7:0] <= {i_pwdata[7:4], 4'h0};
         if (wr_exc && hi_ok) exc[15:8] <= i_pwdata[15:8];
         if (wr_msk && lo_ok) irq_msk[7:0] <= i_pwdata[7:0];
         if (wr_msk && hi_ok) irq_msk[15:8] <= i_pwdata[15:8];
      end
   end

   // ***********************************
   // status and monitor gating
   // ***********************************
   wire [1:0] mon_sel = ctrl1[ABX_MON_LO+:2];
   wire l0_en = (mon_sel == ABX_MON_L0) || (mon_sel == ABX_MON_BOTH)
                || (mon_sel == ABX_MON_L0PT);
   wire l1_en = (mon_sel == ABX_MON_BOTH);
   wire por_clr = wr_stat && lo_ok && i_pwdata[ABX_POR_BIT];

   wire [15:0] stat = {4'h0,
                       mon_s2.overrange,
                       por_flag,
                       mon_s2.uvlo,
                       mon_s2.rail,
                       mon_s2.ref_l1 && l1_en,
                       mon_s2.ref_l0 && l0_en};
   wire [15:0] rise = stat & ~stat_prev;
   wire [15:0] clr_lo = (wr_ist && lo_ok) ? {8'h00, i_pwdata[7:0]}
                                          : 16'h0000;
   wire [15:0] clr_hi = (wr_ist && hi_ok) ? {i_pwdata[15:8], 8'h00}
                                          : 16'h0000;
   // set wins over write-one clear
   wire [15:0] next_irq_st = (irq_st & ~(clr_lo | clr_hi)) | rise;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         por_flag  <= 1'b1;
         stat_prev <= 16'h00C0;
         irq_st    <= 16'h0000;
      end else begin
         if (por_clr) por_flag <= 1'b0;
         stat_prev <= stat;
         irq_st <= next_irq_st;
      end
   end

   assign o_irq = |(irq_st & irq_msk);

   // ***********************************
   // read data
   // ***********************************
   wire [15:0] rd_mux = hit_c1   ? ctrl1 :
                        hit_exc  ? exc :
                        hit_stat ? stat :
                        hit_ist  ? irq_st :
                        hit_msk  ? irq_msk : 16'h0000;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) o_prdata <= 32'h0000_0000;
      else if (setup && !i_pwrite) o_prdata <= {16'h0000, rd_mux};
   end

   // ***********************************
   // analog control decode
   // ***********************************
   function automatic logic [11:0] mag_ua(input logic [3:0] code);
      unique case (code)
         4'h0:    mag_ua = 12'd0;
         4'h1:    mag_ua = 12'd10;
         4'h2:    mag_ua = 12'd50;
         4'h3:    mag_ua = 12'd100;
         4'h4:    mag_ua = 12'd250;
         4'h5:    mag_ua = 12'd500;
         4'h6:    mag_ua = 12'd750;
         4'h7:    mag_ua = 12'd1000;
         4'h8:    mag_ua = 12'd1500;
         4'h9:    mag_ua = 12'd2000;
         default: mag_ua = 12'd0;
      endcase
   endfunction : mag_ua

   function automatic logic [15:0] pin_sel(input logic [3:0] code);
      pin_sel = (code <= ABX_MUX_LAST) ? (16'h0001 << code) : 16'h0000;
   endfunction : pin_sel

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) o_analog <= '0;
      else begin
         o_analog.common_en       <= ctrl1[ABX_VBC_BIT];
         o_analog.input_en        <= ctrl1[5:0];
         o_analog.magnitude_ua    <= mag_ua(exc[ABX_MAG_LO+:4]);
         o_analog.source_a_onehot <= pin_sel(exc[ABX_MUXA_LO+:4]);
         o_analog.source_b_onehot <= pin_sel(exc[ABX_MUXB_LO+:4]);
         o_analog.ref_l0_en       <= l0_en;
         o_analog.ref_l1_en       <= l1_en;
      end
   end

   // ***********************************
   // assertions
   // ***********************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   por_clear_a: assert property (por_clr |=> !por_flag)
      else $error("power-on flag not cleared");

   por_hold_a: assert property (!por_flag |=> !por_flag)
      else $error("power-on flag set again");

   mon_sync_a: assert property ($changed(i_mon.overrange) |-> ##2
      stat[11:8] == $past(i_mon.overrange, 2))
      else $error("over-range not synced in two cycles");

   ref_gate_a: assert property (mon_sel == ABX_MON_OFF |->
      stat[1:0] == 2'h0)
      else $error("reference flags active while off");

   l1_only_a: assert property (mon_sel != ABX_MON_BOTH |-> !stat[1])
      else $error("level one flag without monitor");

   mag_a: assert property (wr_exc && hi_ok && i_pwdata[15:12] == 4'h9
      |=> ##1 o_analog.magnitude_ua == 12'd2000)
      else $error("magnitude decode wrong");

   muxa_off_a: assert property (exc[7:4] > ABX_MUX_LAST |=>
      o_analog.source_a_onehot == 16'h0000)
      else $error("source a not disconnected");

   muxb_a: assert property (exc[11:8] <= ABX_MUX_LAST |=>
      $onehot(o_analog.source_b_onehot))
      else $error("source b not routed");

   bias_a: assert property (wr_c1 && lo_ok |=> ##1
      o_analog.input_en == $past(i_pwdata[5:0], 2))
      else $error("bias enables not applied");

   common_a: assert property (wr_c1 && lo_ok |=> ##1
      o_analog.common_en == $past(i_pwdata[6], 2))
      else $error("common bias not applied");

   uv_a: assert property (stat[ABX_UV_BIT] == mon_s2.uvlo)
      else $error("undervoltage flag mismatch");

   rail_a: assert property (stat[5:2] == mon_s2.rail)
      else $error("rail flags mismatch");

   ready_a: assert property (setup && state == ABX_IDLE |=> o_pready)
      else $error("no ready after setup");

   unmap_wr_a: assert property (acc && i_pwrite && !mapped |=>
      $stable(ctrl1) && $stable(exc) && $stable(irq_msk))
      else $error("unmapped write changed a register");

   ready_pulse_a: assert property (o_pready
      |=> !o_pready)
      else $error("ready longer than one cycle");

   rdata_hi_a: assert property (o_prdata[31:16]
      == 16'h0000)
      else $error("read data upper half not zero");

   rdata_cap_a: assert property (setup && !i_pwrite && state == ABX_IDLE
      |=> o_prdata[15:0] == $past(rd_mux))
      else $error("read data not captured at setup");

   exc_low_a: assert property (exc[3:0]
      == 4'h0)
      else $error("excitation low nibble not zero");

   irq_mask_a: assert property (irq_msk == 16'h0000
      |-> !o_irq)
      else $error("interrupt while fully masked");

   irq_set_a: assert property (rise != 16'h0000
      |=> (irq_st & $past(rise)) == $past(rise))
      else $error("status event not latched");

   irq_clr_a: assert property (wr_ist && lo_ok && i_pwdata[0] && !rise[0]
      |=> !irq_st[0])
      else $error("interrupt status not cleared");

   irq_hold_a: assert property (irq_st[8] && !wr_ist
      |=> irq_st[8])
      else $error("interrupt status lost");

   por_keep_a: assert property (por_flag && !por_clr
      |=> por_flag)
      else $error("power-on flag lost");

   ctrl_wr_a: assert property (wr_c1 && lo_ok && hi_ok
      |=> ctrl1 == $past(i_pwdata[15:0]))
      else $error("control write not stored");

   exc_wr_a: assert property (wr_exc && lo_ok && hi_ok
      |=> exc == {$past(i_pwdata[15:4]), 4'h0})
      else $error("excitation write not stored");

   ref_l0_a: assert property (l0_en && mon_s2.ref_l0
      |-> stat[0])
      else $error("missing reference not flagged");

   ref_l1_a: assert property (l1_en && mon_s2.ref_l1
      |-> stat[1])
      else $error("low reference not flagged");

   ref_en_a: assert property (o_analog.ref_l1_en
      == $past(l1_en))
      else $error("level one enable not applied");

   ovr_a: assert property (stat[11:8]
      == mon_s2.overrange)
      else $error("over-range flags mismatch");

   // ***********************************
   // cover points
   // ***********************************
   wr_cov: cover property (wr_exc);
   rd_cov: cover property (acc && !i_pwrite && hit_stat);
   irq_cov: cover property (o_irq);
   por_cov: cover property (por_clr);
   b2b_cov: cover property (o_pready ##1 setup);
endmodule : abx_regs
